/* File: design/i2c_burst_monitor.sv */
// two-wire controller: line monitor, master burst engine, own address slave
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "i2c_burst_regs.svh"
module i2c_burst_monitor
  import i2c_burst_pkg::*;
(
  input  wire logic        aclk,     // system clock
  input  wire logic        aresetn,  // synchronous reset, low
  input  wire logic [11:0] awaddr,   // write address
  input  wire logic        awvalid,  // write address valid
  output logic             awready,  // write address ready
  input  wire logic [31:0] wdata,    // write data
  input  wire logic [3:0]  wstrb,    // write byte enables
  input  wire logic        wvalid,   // write data valid
  output logic             wready,   // write data ready
  output logic [1:0]       bresp,    // write response
  output logic             bvalid,   // write response valid
  input  wire logic        bready,   // write response ready
  input  wire logic [11:0] araddr,   // read address
  input  wire logic        arvalid,  // read address valid
  output logic             arready,  // read address ready
  output logic [31:0]      rdata,    // read data
  output logic [1:0]       rresp,    // read response
  output logic             rvalid,   // read data valid
  input  wire logic        rready,   // read data ready
  input  wire logic        serial_clock_line,       // clock line level
  output logic             serial_clock_line_drive, // clock line drive value, always 0
  output logic             serial_clock_line_oe,    // pull clock line low
  input  wire logic        serial_data_line,        // data line level
  output logic             serial_data_line_drive,  // data line drive value, always 0
  output logic             serial_data_line_oe,     // pull data line low
  output logic             irq                   // level interrupt
);
  // ----------------------------------------
  // register decode
  // ----------------------------------------
  function automatic reg_sel_e decode(input logic [11:0] a);
    case (a)
      `OFF_CONTROL:    decode = R_CONTROL;
      `OFF_MONITOR:    decode = R_MONITOR;
      `OFF_BURST_LEN:  decode = R_BLEN;
      `OFF_BURST_CNT:  decode = R_BCNT;
      `OFF_BURST_CTRL: decode = R_BCTRL;
      `OFF_TX_DATA:    decode = R_TXD;
      `OFF_IRQ_STATUS: decode = R_IST;
      `OFF_IRQ_MASK:   decode = R_IMASK;
      `OFF_OWN_ADDR:   decode = R_OWN;
      default:         decode = R_NONE;
    endcase
  endfunction

  localparam logic [9:0] QTR = 10'(`SCL_QUARTER_CYC);

  logic [11:0]   aw_addr;
  logic [31:0]   w_data;
  logic [3:0]    w_strb;
  logic          aw_hold, w_hold;
  logic          slave_function_enable, master_function_enable;
  logic [7:0]    burst_length, burst_countdown, tx_data;
  logic [6:0]    own_address_field, target_addr;
  logic [3:0]    irq_status, irq_mask, events;
  logic          scl_m, scl_s, sda_m, sda_s, scl_p, sda_p;
  master_state_e m_st;
  slave_state_e  s_st;
  logic [9:0]    qcnt;
  logic [1:0]    ph;
  logic [3:0]    bitn, s_bits;
  logic [7:0]    shreg, s_sh;
  logic          addr_phase, m_end, m_scl, m_sda, s_ack;
  logic          wr_now, go_req, tick;
  logic [2:0]    m_ev;
  logic          s_ev;

  assign wr_now = aw_hold && w_hold && !bvalid;
  assign go_req = wr_now && decode(aw_addr) == R_BCTRL && w_strb[1] && w_data[`BCTL_GO_BIT];
  assign tick   = (qcnt == QTR - 10'd1);
  // master and slave events live in separate flops so each has one writer
  assign events = {s_ev, m_ev};

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= 12'h000;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= 2'b00;
    end else begin
      if (awvalid && awready) begin
        aw_hold <= 1'b1;
        awready <= 1'b0;
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold <= 1'b1;
        wready <= 1'b0;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (wr_now) begin
        bvalid  <= 1'b1;
        bresp   <= (decode(aw_addr) == R_NONE) ? 2'b10 : 2'b00;
        aw_hold <= 1'b0;
        w_hold  <= 1'b0;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= 2'b00;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= (decode(araddr) == R_NONE) ? 2'b10 : 2'b00;
      case (decode(araddr))
        R_CONTROL: rdata <= {26'h0, slave_function_enable, master_function_enable, 4'h0};
        R_MONITOR: rdata <= {30'h0, sda_s, scl_s};
        R_BLEN:    rdata <= {24'h0, burst_length};
        R_BCNT:    rdata <= {24'h0, burst_countdown};
        R_BCTRL:   rdata <= {22'h0, m_st != M_IDLE, 2'b00, target_addr};
        R_TXD:     rdata <= {24'h0, tx_data};
        R_IST:     rdata <= {28'h0, irq_status};
        R_IMASK:   rdata <= {28'h0, irq_mask};
        R_OWN:     rdata <= {25'h0, own_address_field};
        default:   rdata <= 32'h0000_0000;
      endcase
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ----------------------------------------
  // writable registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slave_function_enable               <= 1'b0;
      master_function_enable               <= 1'b0;
      burst_length      <= 8'h00;
      tx_data           <= 8'h00;
      target_addr       <= 7'h00;
      irq_mask          <= 4'h0;
      own_address_field <= 7'h00;
    end else if (wr_now && w_strb[0]) begin
      case (decode(aw_addr))
        R_CONTROL: {slave_function_enable, master_function_enable} <= {w_data[`CTL_SFE_BIT], w_data[`CTL_MFE_BIT]};
        R_BLEN:    burst_length <= w_data[7:0];
        R_BCTRL:   target_addr <= w_data[6:0];
        R_TXD:     tx_data <= w_data[7:0];
        R_IMASK:   irq_mask <= w_data[3:0];
        R_OWN:     own_address_field <= w_data[6:0];
        default:   ;
      endcase
    end
  end

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= 4'h0;
      irq        <= 1'b0;
    end else begin
      if (wr_now && w_strb[0] && decode(aw_addr) == R_IST)
        irq_status <= (irq_status & ~w_data[3:0]) | events;
      else
        irq_status <= irq_status | events;
      irq <= |(irq_status & irq_mask);
    end
  end

  // ----------------------------------------
  // line synchronisers
  // ----------------------------------------
  // clock and data levels sampled, both idle high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {scl_m, scl_s, scl_p} <= {`MONITOR_RESET, 1'b1};
      {sda_m, sda_s, sda_p} <= {`MONITOR_RESET, 1'b1};
    end else begin
      {scl_m, scl_s, scl_p} <= {serial_clock_line, scl_m, scl_s};
      {sda_m, sda_s, sda_p} <= {serial_data_line, sda_m, sda_s};
    end
  end

  // ----------------------------------------
  // master burst engine
  // ----------------------------------------
  // no clock stretching: the engine owns the clock pace while busy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      m_st            <= M_IDLE;
      qcnt            <= 10'h000;
      ph              <= 2'b00;
      bitn            <= 4'h0;
      shreg           <= 8'h00;
      addr_phase      <= 1'b0;
      m_end           <= 1'b0;
      m_scl           <= 1'b0;
      m_sda           <= 1'b0;
      burst_countdown <= 8'h00;
      m_ev            <= 3'h0;
    end else begin
      m_ev <= 3'h0;
      qcnt <= (m_st == M_IDLE || tick) ? 10'h000 : qcnt + 10'h001;
      if (m_st != M_IDLE && tick)
        ph <= ph + 2'b01;
      if (!master_function_enable) begin
        m_st  <= M_IDLE;
        m_scl <= 1'b0;
        m_sda <= 1'b0;
        ph    <= 2'b00;
      end else begin
        case (m_st)
          M_IDLE: begin
            ph <= 2'b00;
            if (go_req && burst_length == 8'h00) begin
              m_ev[`EV_ZERO_LEN] <= 1'b1;
            end else if (go_req) begin
              burst_countdown <= burst_length;
              shreg           <= {target_addr, 1'b0};
              addr_phase      <= 1'b1;
              bitn            <= 4'h0;
              m_end           <= 1'b0;
              m_st            <= M_START;
            end
          end
          M_START: if (tick) begin
            if (ph == 2'b00)
              m_sda <= 1'b1;
            else begin
              m_scl <= 1'b1;
              ph    <= 2'b00;
              m_st  <= M_BITS;
            end
          end
          M_BITS: if (tick) begin
            case (ph)
              2'b00: m_sda <= (bitn == 4'h8) ? 1'b0 : ~shreg[7];
              2'b01: m_scl <= 1'b0;
              2'b10: if (bitn == 4'h8) begin
                if (sda_s) begin
                  m_end                <= 1'b1;
                  m_ev[`EV_NACK]       <= 1'b1;
                end else if (!addr_phase) begin
                  burst_countdown <= burst_countdown - 8'h01;
                  if (burst_countdown == 8'h01) begin
                    m_end            <= 1'b1;
                    m_ev[`EV_DONE]   <= 1'b1;
                  end
                end
              end
              default: begin
                m_scl <= 1'b1;
                if (bitn == 4'h8) begin
                  bitn       <= 4'h0;
                  shreg      <= tx_data;
                  addr_phase <= 1'b0;
                  if (m_end)
                    m_st <= M_STOP;
                end else begin
                  bitn  <= bitn + 4'h1;
                  shreg <= {shreg[6:0], 1'b0};
                end
              end
            endcase
          end
          M_STOP: if (tick) begin
            case (ph)
              2'b00:   m_sda <= 1'b1;
              2'b01:   m_scl <= 1'b0;
              2'b10:   m_sda <= 1'b0;
              default: m_st  <= M_IDLE;
            endcase
          end
          default: m_st <= M_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // own address slave
  // ----------------------------------------
  // answers the address byte only; data phases are left to other logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_st      <= S_IDLE;
      s_bits    <= 4'h0;
      s_sh      <= 8'h00;
      s_ack     <= 1'b0;
      s_ev      <= 1'b0;
    end else begin
      s_ev <= 1'b0;
      if (scl_s && scl_p && sda_p && !sda_s) begin
        s_st   <= S_ADDR;
        s_bits <= 4'h0;
        s_ack  <= 1'b0;
      end else if (scl_s && scl_p && !sda_p && sda_s) begin
        s_st  <= S_IDLE;
        s_ack <= 1'b0;
      end else begin
        case (s_st)
          S_ADDR: begin
            if (scl_s && !scl_p) begin
              s_sh   <= {s_sh[6:0], sda_s};
              s_bits <= s_bits + 4'h1;
            end else if (!scl_s && scl_p && s_bits == 4'h8) begin
              if (slave_function_enable && s_sh[7:1] == own_address_field) begin
                s_ack                  <= 1'b1;
                s_ev                   <= 1'b1;
                s_st                   <= S_ACK;
              end else
                s_st <= S_IDLE;
            end
          end
          S_ACK: if (!scl_s && scl_p) begin
            s_ack <= 1'b0;
            s_st  <= S_IDLE;
          end
          default: s_st <= S_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_clock_line_oe <= 1'b0;
      serial_data_line_oe  <= 1'b0;
      serial_clock_line_drive <= 1'b0;
      serial_data_line_drive  <= 1'b0;
    end else begin
      serial_clock_line_oe <= m_scl;
      serial_data_line_oe  <= m_sda | s_ack;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_mon_sda;
    arvalid && arready && decode(araddr) == R_MONITOR |=> rdata[1] == $past(sda_s);
  endproperty
  a_mon_sda: assert property (p_mon_sda) else $error("monitor data bit wrong");

  property p_mon_scl;
    arvalid && arready && decode(araddr) == R_MONITOR |=> rdata[0] == $past(scl_s);
  endproperty
  a_mon_scl: assert property (p_mon_scl) else $error("monitor clock bit wrong");

  property p_load;
    m_st == M_IDLE && master_function_enable && go_req && burst_length != 8'h00
      |=> m_st == M_START && burst_countdown == $past(burst_length);
  endproperty
  a_load: assert property (p_load) else $error("countdown not loaded");

  property p_dec;
    m_st == M_BITS && tick && ph == 2'b10 && bitn == 4'h8 && !sda_s && !addr_phase && master_function_enable
      |=> burst_countdown == $past(burst_countdown) - 8'h01;
  endproperty
  a_dec: assert property (p_dec) else $error("countdown not decremented");

  property p_nack;
    m_st == M_BITS && tick && ph == 2'b10 && bitn == 4'h8 && sda_s && master_function_enable
      |=> burst_countdown == $past(burst_countdown) && events[`EV_NACK];
  endproperty
  a_nack: assert property (p_nack) else $error("nack did not end burst");

  property p_done;
    events[`EV_DONE] |-> burst_countdown == 8'h00;
  endproperty
  a_done: assert property (p_done) else $error("done with nonzero count");

  property p_zero;
    m_st == M_IDLE && master_function_enable && go_req && burst_length == 8'h00
      |=> events[`EV_ZERO_LEN] && m_st == M_IDLE ##1 irq_status[`EV_ZERO_LEN];
  endproperty
  a_zero: assert property (p_zero) else $error("zero length not flagged");

  property p_mfe;
    !master_function_enable |=> m_st == M_IDLE && !m_scl && !m_sda;
  endproperty
  a_mfe: assert property (p_mfe) else $error("master ran while disabled");
endmodule // i2c_burst_monitor

/* File: design/i2c_burst_regs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef I2C_BURST_REGS_SVH
`define I2C_BURST_REGS_SVH
`define OFF_CONTROL      12'h020
`define OFF_MONITOR      12'h02c
`define OFF_BURST_LEN    12'h030
`define OFF_BURST_CNT    12'h034
`define OFF_BURST_CTRL   12'h038
`define OFF_TX_DATA      12'h03c
`define OFF_IRQ_STATUS   12'h040
`define OFF_IRQ_MASK     12'h044
`define OFF_OWN_ADDR     12'h800
`define CTL_SFE_BIT      5
`define CTL_MFE_BIT      4
`define MON_SDA_BIT      1
`define MON_SCL_BIT      0
`define BCTL_GO_BIT      8
`define BCTL_BUSY_BIT    9
`define EV_DONE          0
`define EV_NACK          1
`define EV_ZERO_LEN      2
`define EV_SLAVE_ADDR    3
`define MONITOR_RESET    2'h3
`define CLK_PERIOD_NS    5
`define SCL_QUARTER_NS   2500
`define SCL_QUARTER_CYC  ((`SCL_QUARTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* File: design/i2c_burst_pkg.sv */
// types shared by the burst monitor design
package i2c_burst_pkg;
  typedef enum logic [1:0] {
    M_IDLE  = 2'b00,
    M_START = 2'b01,
    M_BITS  = 2'b10,
    M_STOP  = 2'b11
  } master_state_e;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_ADDR = 2'b01,
    S_ACK  = 2'b10
  } slave_state_e;
  typedef enum logic [3:0] {
    R_CONTROL, R_MONITOR, R_BLEN, R_BCNT, R_BCTRL, R_TXD, R_IST, R_IMASK, R_OWN, R_NONE
  } reg_sel_e;
endpackage

/* File: verif/i2c_far_slave.sv */
// far side model: a write-only two-wire slave on pulled-up lines
`timescale 1ns/1ps
module i2c_far_slave #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input  wire logic       scl,        // clock line level
  input  wire logic       sda,        // data line level
  input  wire logic [3:0] nack_at,    // byte index left unacknowledged
  output logic            sda_low,    // pull data line low
  output logic            in_frame,   // between start and stop
  output logic [3:0]      nbytes,     // bytes finished in this frame
  output logic [3:0]      frames,     // starts seen
  output logic [7:0]      first_byte, // address byte of the frame
  output logic [7:0]      last_byte   // latest byte received
);
  logic [3:0] bitc;
  logic [7:0] shreg;
  logic       sel;

  initial begin
    sda_low = 1'b0;
    in_frame = 1'b0;
    nbytes = 4'h0;
    frames = 4'h0;
    bitc = 4'h0;
    sel = 1'b0;
  end

  // start and stop are data edges while the clock is high
  always @(negedge sda) if (scl) begin
    in_frame = 1'b1;
    frames++;
    nbytes = 4'h0;
    bitc = 4'h0;
  end
  always @(posedge sda) if (scl) in_frame = 1'b0;

  always @(posedge scl) if (in_frame && bitc < 4'h8) begin
    shreg = {shreg[6:0], sda};
    bitc++;
  end

  // acknowledge only our own address, and refuse one chosen byte on request
  always @(negedge scl) if (in_frame) begin
    if (bitc == 4'h8) begin
      if (nbytes == 4'h0) begin
        sel = (shreg[7:1] == ADDR);
        first_byte = shreg;
      end
      last_byte = shreg;
      sda_low = sel && (nbytes != nack_at);
      bitc = 4'h9;
    end else if (bitc == 4'h9) begin
      sda_low = 1'b0;
      bitc = 4'h0;
      nbytes++;
    end
  end
endmodule // i2c_far_slave

/* File: verif/testbench.sv */
// self-checking bench for the two-wire burst monitor block
`timescale 1ns/1ps
`include "i2c_burst_regs.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module testbench
  import i2c_burst_pkg::*;
;
  typedef struct { string nm; logic [33:0] v; } exp_s;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, nack_at, nbytes, frames;
  logic [1:0]  bresp, rresp;
  logic        scl_o, scl_oe, sda_o, sda_oe, p_sda_low, tb_scl_low, tb_sda_low, in_frame;
  logic [7:0]  first_byte, last_byte, txd;
  logic [6:0]  own;
  int          fails, check_count, cyc, seed;
  exp_s        rq[$], wq[$], e;
  // open-drain lines with pull-ups: low if any party pulls
  wire scl = (scl_oe ? scl_o : 1'b1) & !tb_scl_low;
  wire sda = (sda_oe ? sda_o : 1'b1) & !tb_sda_low & !p_sda_low;

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  i2c_burst_monitor dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .serial_clock_line(scl), .serial_clock_line_drive(scl_o), .serial_clock_line_oe(scl_oe),
    .serial_data_line(sda), .serial_data_line_drive(sda_o), .serial_data_line_oe(sda_oe),
    .irq(irq));

  i2c_far_slave far (.scl(scl), .sda(sda), .nack_at(nack_at), .sda_low(p_sda_low),
    .in_frame(in_frame), .nbytes(nbytes), .frames(frames), .first_byte(first_byte),
    .last_byte(last_byte));

  task automatic end_of_test();
    if (fails == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // two bursts of 100 kHz bytes take about 96k cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 100000) begin
      fails++;
      end_of_test();
    end
  end

  // ------------------------------------------------------------
  // response watcher: oldest note against each bus answer
  // ------------------------------------------------------------
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      if (rq.size() == 0) fails++;
      else begin
        e = rq.pop_front();
        `CHK(e.nm, e.v, {rresp, rdata})
      end
    end
    if (bvalid && bready) begin
      if (wq.size() == 0) fails++;
      else begin
        e = wq.pop_front();
        `CHK(e.nm, e.v[1:0], bresp)
      end
    end
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
    bit ad, wd;
    wq.push_back('{"bresp", {32'h0000_0000, r}});
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    ad = 0;
    wd = 0;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        ad = 1;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wd = 1;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input string nm,
                    input logic [1:0] r = 2'b00);
    rq.push_back('{nm, {r, d}});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  // one burst to the far slave at address 2a; nk picks the refused byte
  task automatic burst(input logic [7:0] len, input logic [3:0] nk, input logic [31:0] st,
                       input logic [31:0] cnt);
    txd = 8'($random(seed));
    nack_at <= nk;
    wr(`OFF_TX_DATA, {24'h00_0000, txd});
    wr(`OFF_BURST_LEN, {24'h00_0000, len});
    wr(`OFF_BURST_CTRL, 32'h0000_012a);
    rd(`OFF_BURST_CNT, {24'h00_0000, len}, "count_loaded");
    rd(`OFF_BURST_CTRL, 32'h0000_022a, "busy_set");
    if (len == 8'h02) begin
      wait (nbytes == 4'h2);
      rd(`OFF_BURST_CNT, 32'h0000_0001, "count_step");
    end
    while (irq !== 1'b1) @(posedge aclk);
    wait (in_frame === 1'b0);
    // the engine idles one quarter after the stop; a go before then is ignored
    repeat (`SCL_QUARTER_CYC + 4) @(posedge aclk);
    rd(`OFF_BURST_CTRL, 32'h0000_002a, "busy_clear");
    rd(`OFF_IRQ_STATUS, st, "status_end");
    rd(`OFF_BURST_CNT, cnt, "count_end");
    `CHK("addr_byte", 8'h54, first_byte)
    `CHK("data_byte", txd, last_byte)
    wr(`OFF_IRQ_STATUS, 32'h0000_000f);
  endtask

  // link clock of 125 ns made by the bench as a foreign master
  task automatic slave_frame(input logic ack);
    logic [7:0] b;
    b = {own, 1'b0};
    @(posedge aclk);
    tb_sda_low <= 1'b1;
    repeat (13) @(posedge aclk);
    tb_scl_low <= 1'b1;
    for (int i = 7; i >= 0; i--) begin
      repeat (6) @(posedge aclk);
      tb_sda_low <= !b[i];
      repeat (7) @(posedge aclk);
      tb_scl_low <= 1'b0;
      repeat (12) @(posedge aclk);
      tb_scl_low <= 1'b1;
    end
    repeat (6) @(posedge aclk);
    tb_sda_low <= 1'b0;
    repeat (7) @(posedge aclk);
    tb_scl_low <= 1'b0;
    repeat (6) @(posedge aclk);
    `CHK("slave_ack", !ack, sda)
    repeat (6) @(posedge aclk);
    tb_scl_low <= 1'b1;
    repeat (6) @(posedge aclk);
    tb_sda_low <= 1'b1;
    repeat (7) @(posedge aclk);
    tb_scl_low <= 1'b0;
    repeat (13) @(posedge aclk);
    tb_sda_low <= 1'b0;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 33581;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, tb_scl_low, tb_sda_low} = 7'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
    nack_at = 4'hf;
    own = {1'b1, 6'($random(seed))};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`OFF_MONITOR, 32'h0000_0003, "monitor_reset");
    rd(`OFF_BURST_LEN, 32'h0000_0000, "length_reset");
    rd(`OFF_BURST_CNT, 32'h0000_0000, "count_reset");
    rd(`OFF_OWN_ADDR, 32'h0000_0000, "own_reset");
    wr(`OFF_BURST_LEN, 32'hffff_ffa5);
    rd(`OFF_BURST_LEN, 32'h0000_00a5, "length_rw");
    wr(`OFF_BURST_CNT, 32'h0000_0077);
    rd(`OFF_BURST_CNT, 32'h0000_0000, "count_ro");
    wr(`OFF_OWN_ADDR, 32'hffff_ffff);
    rd(`OFF_OWN_ADDR, 32'h0000_007f, "own_rw");
    wr(`OFF_OWN_ADDR, {25'h000_0000, own});
    wr(12'h100, 32'h0000_0001, 2'b10);
    rd(12'h100, 32'h0000_0000, "unmapped", 2'b10);
    tb_scl_low <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(`OFF_MONITOR, 32'h0000_0002, "monitor_scl");
    tb_sda_low <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(`OFF_MONITOR, 32'h0000_0000, "monitor_sda");
    tb_sda_low <= 1'b0;
    repeat (4) @(posedge aclk);
    tb_scl_low <= 1'b0;
    wr(`OFF_BURST_LEN, 32'h0000_0001);
    wr(`OFF_BURST_CTRL, 32'h0000_012a);
    repeat (20) @(posedge aclk);
    `CHK("frames_disabled", 4'h0, frames)
    wr(`OFF_CONTROL, 32'h0000_0010);
    wr(`OFF_IRQ_MASK, 32'h0000_0004);
    wr(`OFF_BURST_LEN, 32'h0000_0000);
    wr(`OFF_BURST_CTRL, 32'h0000_012a);
    repeat (5) @(posedge aclk);
    `CHK("irq_zero_len", 1'b1, irq)
    rd(`OFF_IRQ_STATUS, 32'h0000_0004, "status_zero_len");
    `CHK("frames_zero_len", 4'h0, frames)
    wr(`OFF_IRQ_MASK, 32'h0000_0000);
    repeat (3) @(posedge aclk);
    `CHK("irq_masked", 1'b0, irq)
    wr(`OFF_IRQ_STATUS, 32'h0000_0004);
    rd(`OFF_IRQ_STATUS, 32'h0000_0000, "status_clear");
    wr(`OFF_IRQ_MASK, 32'h0000_0003);
    burst(8'h02, 4'h2, 32'h0000_0002, 32'h0000_0001);
    burst(8'h01, 4'hf, 32'h0000_0001, 32'h0000_0000);
    wr(`OFF_CONTROL, 32'h0000_0010);
    slave_frame(1'b0);
    wr(`OFF_CONTROL, 32'h0000_0030);
    slave_frame(1'b1);
    rd(`OFF_IRQ_STATUS, 32'h0000_0008, "slave_status");
    end_of_test();
  end
endmodule // testbench
